// ==== logic/frame_rx_consts.vh ====
// constants for the serial control frame receiver
// assumes inclusion by bare name from the design file
`ifndef FRAME_RX_CONSTS_VH
`define FRAME_RX_CONSTS_VH

// frame layout: sync code, then a word whose bit 0 is received first
`define SYNC_BITS        8
`define WORD_BITS        40
`define CNT_W            6
`define LAST_BIT_IDX     6'h27
`define SYNC_HEAD        6'h1F
`define SYNC_HEAD_W      6
`define TR_CODE_BAD      2'h3
`define FIVE_ONES        5'h1F
`define SYNC_GEN_CODE    8'h7D

// word fields, positions inside the 40-bit word
`define INHIBIT_BIT      0
`define RET_MON_BIT      1
`define ID_LSB           2
`define ID_W             3
`define DATA_LSB         8
`define DATA_W           32

// word identities
`define ID_MONITOR       3'h0
`define ID_FREQ          3'h1
`define ID_ANALOGUE      3'h2
`define ID_MODE          3'h5

// register offsets and fields
`define ADDR_W           8
`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define REG_FRAMES       8'h08
`define REG_FAILS        8'h0C
`define CTRL_RX_EN_BIT   0
`define CTRL_RESET       32'h00000001
`define STAT_IN_FRAME    0
`define STAT_MATCH       1
`define STAT_INHIBIT     2
`define STAT_RET_MON     3
`define STAT_ID_LSB      4
`define CNT_REG_W        16

// idle level of the revertive data line
`define REV_IDLE         1'h1

`endif

// ==== logic/serial_control_frame_receiver.v ====
// serial control frame receiver: sync search, frame compare, word decode,
// parallel strobes to the receiver and revertive frame generation.
// assumes link clock and data arrive asynchronously and are far slower
// than ref_clk_i; monitor_data_i comes from logic on ref_clk_i.
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "frame_rx_consts.vh"
`default_nettype none

module serial_control_frame_receiver #(
    parameter ID_LSB = `ID_LSB,
    parameter ID_W   = `ID_W
)(
    input  wire                    ref_clk_i,
    input  wire                    rst_i,
    input  wire                    link_clk_i,
    input  wire                    link_data_i,
    input  wire [`WORD_BITS-1:0]   monitor_data_i,
    input  wire [`ADDR_W-1:0]      reg_addr_i,
    input  wire [31:0]             reg_wdata_i,
    input  wire                    reg_wr_i,
    input  wire                    reg_rd_i,
    output reg  [31:0]             reg_rdata_o,
    output reg                     rev_clk_o,
    output reg                     rev_data_o,
    output reg                     enable_o,
    output reg                     mon_load_o,
    output reg  [`DATA_W-1:0]      freq_data_o,
    output reg                     freq_strobe_o,
    output reg  [`DATA_W-1:0]      anal_data_o,
    output reg                     anal_strobe_o,
    output reg  [`DATA_W-1:0]      mode_data_o,
    output reg                     mode_strobe_o
);

    function [`SYNC_BITS-1:0] rev8;
        input [`SYNC_BITS-1:0] v;
        integer i;
        begin
            for (i = 0; i < `SYNC_BITS; i = i + 1)
                rev8[i] = v[`SYNC_BITS-1-i];
        end
    endfunction

    function is_id;
        input [`WORD_BITS-1:0] w;
        input [ID_W-1:0]       id;
        begin
            is_id = (w[ID_LSB +: ID_W] == id);
        end
    endfunction

    // link synchronisers; first stages feed only the second stages
    reg                    clk_s1_r;
    reg                    clk_s2_r;
    reg                    clk_s3_r;
    reg                    dat_s1_r;
    reg                    dat_s2_r;
    wire                   link_rise;
    wire                   link_fall;

    reg  [`SYNC_BITS-1:0]  win_r;
    wire [`SYNC_BITS-1:0]  win_nxt;
    wire                   sync_hit;
    wire                   five_ones;
    reg                    in_frame_r;
    reg  [`CNT_W-1:0]      bit_cnt_r;
    reg                    mism_r;
    reg                    eof_r;
    reg  [`WORD_BITS-1:0]  word_r;

    reg  [`WORD_BITS-1:0]  mon_out_r;
    reg  [`WORD_BITS-1:0]  freq_out_r;
    reg  [`WORD_BITS-1:0]  anal_out_r;
    reg  [`WORD_BITS-1:0]  mode_out_r;
    reg  [`WORD_BITS+`SYNC_BITS-1:0] tx_r;
    reg  [`CNT_W-1:0]      tx_cnt_r;
    reg                    tx_busy_r;

    reg  [31:0]            ctrl_r;
    reg                    last_match_r;
    reg                    last_inh_r;
    reg                    last_rm_r;
    reg  [ID_W-1:0]        last_id_r;
    reg  [`CNT_REG_W-1:0]  frames_r;
    reg  [`CNT_REG_W-1:0]  fails_r;

    // end-of-frame decode
    wire                   inhibit;
    wire                   ret_mon;
    wire                   en;
    wire                   hit_freq;
    wire                   hit_anal;
    wire                   hit_mode;
    wire                   mon_ld;
    wire                   freq_ld;
    wire [`DATA_W-1:0]     data_field;
    reg  [`WORD_BITS-1:0]  tx_word;

    assign link_rise = clk_s2_r & ~clk_s3_r;
    assign link_fall = ~clk_s2_r & clk_s3_r;

    assign win_nxt   = {win_r[`SYNC_BITS-2:0], dat_s2_r};
    assign sync_hit  = (win_nxt[`SYNC_BITS-1:2] == `SYNC_HEAD)
                     && (win_nxt[1:0] != `TR_CODE_BAD);
    assign five_ones = (win_nxt[4:0] == `FIVE_ONES);

    assign inhibit    = word_r[`INHIBIT_BIT];
    assign ret_mon    = word_r[`RET_MON_BIT];
    assign en         = ~mism_r | inhibit;
    assign hit_freq   = en & is_id(word_r, `ID_FREQ);
    assign hit_anal   = en & is_id(word_r, `ID_ANALOGUE);
    assign hit_mode   = en & is_id(word_r, `ID_MODE);
    assign freq_ld    = hit_freq & ~ret_mon;
    // identity zero, a failed compare without inhibit, or a frequency word with the return-monitor bit set all load monitor
    assign mon_ld     = is_id(word_r, `ID_MONITOR) | ~en | (hit_freq & ret_mon);
    assign data_field = word_r[`DATA_LSB +: `DATA_W];

    // word chosen for the next revertive frame; one load per frame, so no queue deeper than one
    always @*
    begin
        tx_word = mon_out_r;
        if (mon_ld)
            tx_word = monitor_data_i;
        else if (freq_ld)
            tx_word = word_r;
        else if (hit_anal)
            tx_word = word_r;
        else if (hit_mode)
            tx_word = word_r;
    end

    always @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            // link clock idles high; resetting to its idle level avoids a false edge after reset
            clk_s1_r <= 1'h1;
            clk_s2_r <= 1'h1;
            clk_s3_r <= 1'h1;
            dat_s1_r <= 1'h0;
            dat_s2_r <= 1'h0;
            rev_clk_o <= 1'h0;
        end
        else
        begin
            clk_s1_r <= link_clk_i;
            clk_s2_r <= clk_s1_r;
            clk_s3_r <= clk_s2_r;
            dat_s1_r <= link_data_i;
            dat_s2_r <= dat_s1_r;
            rev_clk_o <= clk_s2_r;
        end
    end

    // sync search, frame counter, input register and comparator
    always @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            win_r      <= {`SYNC_BITS{1'h0}};
            in_frame_r <= 1'h0;
            bit_cnt_r  <= {`CNT_W{1'h0}};
            mism_r     <= 1'h0;
            eof_r      <= 1'h0;
            word_r     <= {`WORD_BITS{1'h0}};
        end
        else
        begin
            eof_r <= 1'h0;
            if (link_rise)
            begin
                win_r <= win_nxt;
                if (in_frame_r)
                begin
                    word_r    <= {dat_s2_r, word_r[`WORD_BITS-1:1]};
                    mism_r    <= mism_r | (dat_s2_r ^ word_r[0]);
                    bit_cnt_r <= bit_cnt_r + 1'h1;
                    if (five_ones)
                        in_frame_r <= 1'h0;
                    else if (bit_cnt_r == `LAST_BIT_IDX)
                    begin
                        in_frame_r <= 1'h0;
                        eof_r      <= 1'h1;
                    end
                end
                else if (sync_hit && ctrl_r[`CTRL_RX_EN_BIT])
                begin
                    in_frame_r <= 1'h1;
                    bit_cnt_r  <= {`CNT_W{1'h0}};
                    mism_r     <= 1'h0;
                end
            end
        end
    end

    // word decode, strobes and output register loads
    always @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            enable_o      <= 1'h0;
            mon_load_o    <= 1'h0;
            freq_strobe_o <= 1'h0;
            anal_strobe_o <= 1'h0;
            mode_strobe_o <= 1'h0;
            freq_data_o   <= {`DATA_W{1'h0}};
            anal_data_o   <= {`DATA_W{1'h0}};
            mode_data_o   <= {`DATA_W{1'h0}};
            mon_out_r     <= {`WORD_BITS{1'h0}};
            freq_out_r    <= {`WORD_BITS{1'h0}};
            anal_out_r    <= {`WORD_BITS{1'h0}};
            mode_out_r    <= {`WORD_BITS{1'h0}};
        end
        else
        begin
            enable_o      <= eof_r & en;
            mon_load_o    <= eof_r & mon_ld;
            freq_strobe_o <= eof_r & hit_freq & ~inhibit;
            anal_strobe_o <= eof_r & hit_anal & ~inhibit;
            mode_strobe_o <= eof_r & hit_mode & ~inhibit;
            if (eof_r)
            begin
                if (mon_ld)
                    mon_out_r <= monitor_data_i;
                if (freq_ld)
                    freq_out_r <= word_r;
                if (hit_anal)
                    anal_out_r <= word_r;
                if (hit_mode)
                    mode_out_r <= word_r;
                // inhibited strobes leave the receiver outputs latched
                if (hit_freq && !inhibit)
                    freq_data_o <= data_field;
                if (hit_anal && !inhibit)
                    anal_data_o <= data_field;
                if (hit_mode && !inhibit)
                    mode_data_o <= data_field;
            end
        end
    end

    // revertive frame: starts at end of frame, so it lags the forward word by one frame
    always @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_r       <= {(`WORD_BITS+`SYNC_BITS){1'h0}};
            tx_cnt_r   <= {`CNT_W{1'h0}};
            tx_busy_r  <= 1'h0;
            rev_data_o <= `REV_IDLE;
        end
        else if (eof_r)
        begin
            tx_r      <= {tx_word, rev8(`SYNC_GEN_CODE)};
            tx_cnt_r  <= {`CNT_W{1'h0}};
            tx_busy_r <= 1'h1;
        end
        else if (link_fall)
        begin
            // data changes on the falling edge so the panel samples it stable on the rise
            if (tx_busy_r)
            begin
                rev_data_o <= tx_r[0];
                tx_r       <= {1'h0, tx_r[`WORD_BITS+`SYNC_BITS-1:1]};
                tx_cnt_r   <= tx_cnt_r + 1'h1;
                if (tx_cnt_r == (`LAST_BIT_IDX + `SYNC_BITS'h0) - {`CNT_W{1'h0}} + 6'h08)
                    tx_busy_r <= 1'h0;
            end
            else
                rev_data_o <= `REV_IDLE;
        end
    end

    // register port and status capture
    always @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctrl_r       <= `CTRL_RESET;
            reg_rdata_o  <= 32'h00000000;
            last_match_r <= 1'h0;
            last_inh_r   <= 1'h0;
            last_rm_r    <= 1'h0;
            last_id_r    <= {ID_W{1'h0}};
            frames_r     <= {`CNT_REG_W{1'h0}};
            fails_r      <= {`CNT_REG_W{1'h0}};
        end
        else
        begin
            if (eof_r)
            begin
                last_match_r <= ~mism_r;
                last_inh_r   <= inhibit;
                last_rm_r    <= ret_mon;
                last_id_r    <= word_r[ID_LSB +: ID_W];
            end
            // a frame event in the same cycle as a clearing write still counts
            if (eof_r)
                frames_r <= frames_r + 1'h1;
            else if (reg_wr_i && reg_addr_i == `REG_FRAMES)
                frames_r <= {`CNT_REG_W{1'h0}};
            if (eof_r && mism_r)
                fails_r <= fails_r + 1'h1;
            else if (reg_wr_i && reg_addr_i == `REG_FAILS)
                fails_r <= {`CNT_REG_W{1'h0}};
            if (reg_wr_i && reg_addr_i == `REG_CTRL)
                ctrl_r <= {31'h00000000, reg_wdata_i[`CTRL_RX_EN_BIT]};
            reg_rdata_o <= 32'h00000000;
            if (reg_rd_i)
            begin
                case (reg_addr_i)
                    `REG_CTRL:
                        reg_rdata_o <= ctrl_r;
                    `REG_STATUS:
                    begin
                        reg_rdata_o[`STAT_IN_FRAME] <= in_frame_r;
                        reg_rdata_o[`STAT_MATCH]    <= last_match_r;
                        reg_rdata_o[`STAT_INHIBIT]  <= last_inh_r;
                        reg_rdata_o[`STAT_RET_MON]  <= last_rm_r;
                        reg_rdata_o[`STAT_ID_LSB +: ID_W] <= last_id_r;
                    end
                    `REG_FRAMES:
                        reg_rdata_o[`CNT_REG_W-1:0] <= frames_r;
                    `REG_FAILS:
                        reg_rdata_o[`CNT_REG_W-1:0] <= fails_r;
                    default:
                        reg_rdata_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// ==== tb/frame_rx_asserts.sv ====
// checker: pulse, strobe and register-read relations at the receiver ports
// assumes one clock domain; bound onto every receiver instance
`timescale 1ns/1ps
`include "frame_rx_consts.vh"
`default_nettype none
module frame_rx_asserts (
    input wire logic               ref_clk_i,
    input wire logic               rst_i,
    input wire logic [`ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0]        reg_wdata_i,
    input wire logic               reg_wr_i,
    input wire logic               reg_rd_i,
    input wire logic [31:0]        reg_rdata_o,
    input wire logic               enable_o,
    input wire logic               mon_load_o,
    input wire logic [`DATA_W-1:0] freq_data_o,
    input wire logic               freq_strobe_o,
    input wire logic               anal_strobe_o,
    input wire logic [`DATA_W-1:0] mode_data_o,
    input wire logic               mode_strobe_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    sequence ctrl_wr;
        reg_wr_i && reg_addr_i == `REG_CTRL;
    endsequence
    sequence ctrl_rd;
        reg_rd_i && reg_addr_i == `REG_CTRL;
    endsequence
    // only bit 0 survives a control write
    AST_CTRL_BIT0: assert property (ctrl_wr ##1 ctrl_rd |=> reg_rdata_o == {31'h0, $past(reg_wdata_i[0], 2)})
        else $error("control readback wrong");
    AST_EN_PULSE: assert property (enable_o |=> !enable_o)
        else $error("enable longer than one cycle");
    AST_LOAD_PULSE: assert property (mon_load_o |=> !mon_load_o)
        else $error("monitor load longer than one cycle");
    AST_FREQ_EN: assert property (freq_strobe_o |-> enable_o)
        else $error("frequency strobe without enable");
    AST_ANAL_EN: assert property (anal_strobe_o |-> enable_o)
        else $error("analogue strobe without enable");
    AST_MODE_EN: assert property (mode_strobe_o |-> enable_o)
        else $error("mode strobe without enable");
    AST_ONE_STROBE: assert property ($onehot0({freq_strobe_o, anal_strobe_o, mode_strobe_o}))
        else $error("two word strobes at once");
    AST_FREQ_HOLD: assert property ($changed(freq_data_o) |-> freq_strobe_o)
        else $error("frequency data moved without strobe");
    AST_MODE_HOLD: assert property ($changed(mode_data_o) |-> mode_strobe_o)
        else $error("mode data moved without strobe");
    // read data must not linger, or software sees stale values
    AST_RD_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
        else $error("read data outside read cycle");
    AST_UNMAPPED: assert property (reg_rd_i && reg_addr_i == 8'h10 |=> reg_rdata_o == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind serial_control_frame_receiver frame_rx_asserts u_chk (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .enable_o(enable_o),
    .mon_load_o(mon_load_o), .freq_data_o(freq_data_o), .freq_strobe_o(freq_strobe_o),
    .anal_strobe_o(anal_strobe_o), .mode_data_o(mode_data_o), .mode_strobe_o(mode_strobe_o));
`default_nettype wire

// ==== tb/panel_model.sv ====
// panel model: sends control frames, gathers the revertive frame
// assumes the bench calls send_frame right after a ref clock edge
`timescale 1ns/1ps
`default_nettype none
module panel_model (
    input  wire logic ref_clk_i,
    input  wire logic rev_data_i,
    output var  logic link_clk_o,
    output var  logic link_data_o
);
    logic [47:0] rev_frame;
    logic        busy;
    initial
    begin
        link_clk_o  = 1'b1;
        link_data_o = 1'b0;
        rev_frame   = 48'h0;
        busy        = 1'b0;
    end
    // clock stands high between frames; idle data toggles so no stale bit looks valid
    always @(negedge ref_clk_i)
        if (!busy)
            link_data_o <= ~link_data_o;
    // fall and new bit, rise mid-bit; revertive bit is settled by bit end
    task automatic send_frame(input logic [39:0] w);
        logic [47:0] f;
        f    = {w, 8'hBE}; // sync then word bit0 first
        busy = 1'b1;
        for (int i = 0; i < 48; i++)
        begin
            link_clk_o  <= 1'b0;
            link_data_o <= f[i];
            repeat (4) @(posedge ref_clk_i);
            link_clk_o <= 1'b1;
            repeat (4) @(posedge ref_clk_i);
            rev_frame <= {rev_data_i, rev_frame[47:1]};
        end
        busy = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// testbench: register checks and frame sequences through the panel model
// assumes the receiver, checker and panel model are compiled first
`timescale 1ns/1ps
`include "frame_rx_consts.vh"
`default_nettype none
module testbench;
    localparam logic [39:0] MON = 40'hA5C3965AF0;
    localparam logic [39:0] W0  = 40'h0000000000;
    localparam logic [39:0] F   = 40'h1234567804;
    localparam logic [39:0] A   = 40'h2468ACE008;
    localparam logic [39:0] M   = 40'h0F0F3C3C14;
    localparam logic [39:0] FR  = 40'h1234567806;
    localparam logic [39:0] FI  = 40'h0ABC0DEF05;
    localparam logic [39:0] FAB = 40'h0000007F04;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        link_clk;
    logic        link_data;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic        rev_data_o, enable_o, mon_load_o, freq_strobe_o, anal_strobe_o, mode_strobe_o;
    logic [31:0] freq_data_o, anal_data_o, mode_data_o;
    logic [3:0]  pc [5] = '{default: 4'h0};
    int          mismatches = 0;
    int          check_count = 0;
    int          cyc = 0;
    always #25 ref_clk_i = ~ref_clk_i;
    serial_control_frame_receiver dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .link_clk_i(link_clk), .link_data_i(link_data),
        .monitor_data_i(MON), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .rev_clk_o(),
        .rev_data_o(rev_data_o), .enable_o(enable_o), .mon_load_o(mon_load_o),
        .freq_data_o(freq_data_o), .freq_strobe_o(freq_strobe_o), .anal_data_o(anal_data_o),
        .anal_strobe_o(anal_strobe_o), .mode_data_o(mode_data_o), .mode_strobe_o(mode_strobe_o));
    panel_model panel (.ref_clk_i(ref_clk_i), .rev_data_i(rev_data_o), .link_clk_o(link_clk),
        .link_data_o(link_data));
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // pulse counters; a frame takes about 400 cycles, the ceiling leaves margin
    always @(posedge ref_clk_i)
    begin
        pc[0] <= pc[0] + enable_o;
        pc[1] <= pc[1] + mon_load_o;
        pc[2] <= pc[2] + freq_strobe_o;
        pc[3] <= pc[3] + anal_strobe_o;
        pc[4] <= pc[4] + mode_strobe_o;
        cyc <= cyc + 1;
        if (cyc == 12000)
        begin
            mismatches = mismatches + 1;
            final_report;
        end
    end
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        check_count = check_count + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, e);
        @(posedge ref_clk_i);
    endtask
    // expected pulse counts, one nibble each: enable, load, freq, analogue, mode
    task automatic frame(input logic [39:0] w, input logic [19:0] ep);
        logic [3:0] b [5];
        b = pc;
        panel.send_frame(w);
        repeat (10) @(posedge ref_clk_i);
        chk({pc[0] - b[0], pc[1] - b[1], pc[2] - b[2], pc[3] - b[3], pc[4] - b[4]}, ep);
    endtask
    // revertive bits arrive first-at-lsb, so the sync reads bit-reversed
    task automatic rv(input logic [39:0] w);
        chk(panel.rev_frame, {w, 8'hBE});
    endtask
    initial
    begin
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        chk({rev_data_o, enable_o, mon_load_o, freq_strobe_o, anal_strobe_o, mode_strobe_o}, 6'h20);
        rd(`REG_CTRL, 32'h1);
        rd(`REG_FRAMES, 32'h0);
        rd(8'h10, 32'h0);
        frame(W0, 20'h11000);
        frame(W0, 20'h11000);
        rv(MON);
        frame(F, 20'h01000);
        rv(MON);
        frame(F, 20'h10100);
        chk(freq_data_o, F[39:8]);
        rv(MON);
        frame(A, 20'h01000);
        rv(F);
        frame(A, 20'h10010);
        chk(anal_data_o, A[39:8]);
        rv(MON);
        frame(M, 20'h01000);
        rv(A);
        frame(M, 20'h10001);
        chk(mode_data_o, M[39:8]);
        rv(MON);
        frame(FR, 20'h01000);
        rv(M);
        frame(FR, 20'h11100);
        rv(MON);
        rd(`REG_FRAMES, 32'hA);
        rd(`REG_FAILS, 32'h4);
        wr(`REG_FRAMES, 32'h0);
        rd(`REG_FRAMES, 32'h0);
        frame(FI, 20'h10000);
        chk(freq_data_o, F[39:8]);
        rv(MON);
        frame(FI, 20'h10000);
        rv(FI);
        rd(`REG_STATUS, 32'h16);
        frame(FAB, 20'h00000);
        rv(FI);
        wr(8'h10, 32'hFFFFFFFF);
        rd(8'h10, 32'h0);
        wr(`REG_CTRL, 32'hFFFFFFFE);
        rd(`REG_CTRL, 32'h0);
        frame(F, 20'h00000);
        final_report;
    end
endmodule
`default_nettype wire
